// ==== src/ppc_params.svh ====
// Register map, field positions, reset values and timing counts
// Operation
// R1 - Select bit 20 takes the PWM clock from the predivider; resets zero.
// R2 - Bits 19:17 divide by 2,4,8,16,32; codes 5 to 7 by 64; reset 0x7.
// R3 - Divided PWM clock is power-of-two, edges aligned to system clock edges.
// R4 - Bit 13 drives the PLL power-down input; reset one keeps PLL down.
// R5 - Bit 12 low passes the PLL clock out; high blocks it; resets one.
// R6 - Software clears power-down and output-enable bits to run the PLL.
// R7 - Bypass bit 11 set, the reset value, clocks system from oscillator.
// R8 - Bypass bit clear clocks system from PLL through the system divider.
// R9 - Software keeps the converter unused while the PLL is bypassed.
// R10 - Bit 10 enables a PLL verification timer that flags a dead PLL.
// R11 - Reserved bits 21 and 16:14 read fixed and ignore writes.
// R12 - Select bit clear feeds the PWM the undivided system clock.
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PPC_CTRL_OFFSET 12'h000
`define PPC_STAT_OFFSET 12'h004

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PPC_PWM_SEL_BIT 20
`define PPC_PWM_CODE_HI 19
`define PPC_PWM_CODE_LO 17
`define PPC_PWR_DOWN_BIT 13
`define PPC_OUT_EN_N_BIT 12
`define PPC_BYPASS_BIT 11
`define PPC_VERIFY_BIT 10
`define PPC_LOST_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PPC_PWM_SEL_RST 1'b0
`define PPC_PWM_CODE_RST 3'h7
`define PPC_PWR_DOWN_RST 1'b1
`define PPC_OUT_EN_N_RST 1'b1
`define PPC_BYPASS_RST 1'b1
`define PPC_VERIFY_RST 1'b0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PPC_CLK_PERIOD_NS 100
`define PPC_VERIFY_TIME_NS 10000
`define PPC_VERIFY_CYCLES (`PPC_VERIFY_TIME_NS / `PPC_CLK_PERIOD_NS)

`endif

// ==== src/ppc_pkg.sv ====
// Shared types of the PLL and PWM clock select block
package ppc_pkg;
   typedef logic [31:0] ppc_word_t;
   typedef logic [2:0] ppc_div_code_t;
   // Verification timer states
   typedef enum logic [1:0] {
      VF_OFF,
      VF_WATCH,
      VF_LOST
   } ppc_vf_state_t;
endpackage

// ==== src/ppc_clock_select.sv ====
// PLL control, PWM predivider and PLL verification timer with APB access
`timescale 1ns/1ns
`include "ppc_params.svh"
module ppc_clock_select #(
   parameter int VERIFY_CYCLES = `PPC_VERIFY_CYCLES
) (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire ppc_pkg::ppc_word_t PWDATA_I,
   output ppc_pkg::ppc_word_t PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic PLL_MON_I,
   output logic PLL_POWER_DOWN_O,
   output logic PLL_OUTPUT_ENABLE_N_O,
   output logic PLL_BYPASS_O,
   output logic PWM_CLK_EN_O,
   output logic PLL_FAIL_O
);
   import ppc_pkg::*;

   localparam logic [15:0] VF_LAST = 16'(VERIFY_CYCLES - 1);

   // Mask of low divider bits that must be zero for a PWM enable
   function automatic logic [5:0] pwm_mask(input ppc_div_code_t code);
      logic [5:0] m;
      m = 6'h3F;
      if (code < 3'h5) begin
         m = 6'((7'h02 << code) - 7'h01);
      end
      return m;
   endfunction

   // ----------------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------------
   logic pwm_sel_reg, pwm_sel_next;
   ppc_div_code_t pwm_code_reg, pwm_code_next;
   logic pwr_down_reg, pwr_down_next;
   logic out_en_n_reg, out_en_n_next;
   logic bypass_reg, bypass_next;
   logic verify_reg, verify_next;
   logic lost_reg, lost_next;
   logic wr_ctrl, wr_stat, acc, mapped;
   logic lost_set;

   assign acc = PSEL_I && PENABLE_I && PREADY_O;
   assign mapped = (PADDR_I == `PPC_CTRL_OFFSET) ||
                   (PADDR_I == `PPC_STAT_OFFSET);
   assign wr_ctrl = acc && PWRITE_I && (PADDR_I == `PPC_CTRL_OFFSET);
   assign wr_stat = acc && PWRITE_I && (PADDR_I == `PPC_STAT_OFFSET);

   // Writable fields load only at the access edge; reserved bits ignored
   always_comb begin
      pwm_sel_next = pwm_sel_reg;
      pwm_code_next = pwm_code_reg;
      pwr_down_next = pwr_down_reg;
      out_en_n_next = out_en_n_reg;
      bypass_next = bypass_reg;
      verify_next = verify_reg;
      lost_next = lost_reg;
      if (wr_ctrl) begin
         pwm_sel_next = PWDATA_I[`PPC_PWM_SEL_BIT]; // R1
         pwm_code_next = PWDATA_I[`PPC_PWM_CODE_HI:`PPC_PWM_CODE_LO]; // R2
         pwr_down_next = PWDATA_I[`PPC_PWR_DOWN_BIT]; // R4
         out_en_n_next = PWDATA_I[`PPC_OUT_EN_N_BIT]; // R5
         bypass_next = PWDATA_I[`PPC_BYPASS_BIT]; // R7
         verify_next = PWDATA_I[`PPC_VERIFY_BIT]; // R10
      end
      // Write one clears; a loss in the same cycle wins
      if (wr_stat && PWDATA_I[`PPC_LOST_BIT]) begin
         lost_next = 1'b0;
      end
      if (lost_set) begin
         lost_next = 1'b1;
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pwm_sel_reg <= `PPC_PWM_SEL_RST;
         pwm_code_reg <= `PPC_PWM_CODE_RST;
         pwr_down_reg <= `PPC_PWR_DOWN_RST;
         out_en_n_reg <= `PPC_OUT_EN_N_RST;
         bypass_reg <= `PPC_BYPASS_RST;
         verify_reg <= `PPC_VERIFY_RST;
         lost_reg <= 1'b0;
      end else begin
         pwm_sel_reg <= pwm_sel_next;
         pwm_code_reg <= pwm_code_next;
         pwr_down_reg <= pwr_down_next;
         out_en_n_reg <= out_en_n_next;
         bypass_reg <= bypass_next;
         verify_reg <= verify_next;
         lost_reg <= lost_next;
      end
   end

   // Analog controls come straight from the register bits
   assign PLL_POWER_DOWN_O = pwr_down_reg; // R4
   assign PLL_OUTPUT_ENABLE_N_O = out_en_n_reg; // R5
   // One selects oscillator; zero selects PLL after the system divider
   assign PLL_BYPASS_O = bypass_reg; // R7 R8

   // ----------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------
   ppc_word_t rdata_next;
   logic ready_next, err_next;

   // Answer prepared in the setup cycle, so the access phase takes one
   always_comb begin
      rdata_next = PRDATA_O;
      ready_next = PSEL_I && !PENABLE_I;
      err_next = PSEL_I && !PENABLE_I && !mapped;
      if (PSEL_I && !PENABLE_I) begin
         rdata_next = 32'h0000_0000; // R11
         if (PADDR_I == `PPC_CTRL_OFFSET) begin
            rdata_next[`PPC_PWM_SEL_BIT] = pwm_sel_reg;
            rdata_next[`PPC_PWM_CODE_HI:`PPC_PWM_CODE_LO] = pwm_code_reg;
            rdata_next[`PPC_PWR_DOWN_BIT] = pwr_down_reg;
            rdata_next[`PPC_OUT_EN_N_BIT] = out_en_n_reg;
            rdata_next[`PPC_BYPASS_BIT] = bypass_reg;
            rdata_next[`PPC_VERIFY_BIT] = verify_reg;
         end else if (PADDR_I == `PPC_STAT_OFFSET) begin
            rdata_next[`PPC_LOST_BIT] = lost_reg;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         PRDATA_O <= 32'h0000_0000;
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
      end else begin
         PRDATA_O <= rdata_next;
         PREADY_O <= ready_next;
         PSLVERR_O <= err_next;
      end
   end

   // ----------------------------------------------------------------------
   // PWM predivider
   // ----------------------------------------------------------------------
   logic [5:0] div_cnt_reg, div_cnt_next;
   logic pwm_en_next;

   // Free running count; a pulse where the selected low bits are zero
   // keeps every divided edge on a system clock edge with no offset
   always_comb begin
      div_cnt_next = div_cnt_reg + 6'h01;
      pwm_en_next = 1'b1; // R12
      if (pwm_sel_reg) begin
         pwm_en_next =
            (div_cnt_next & pwm_mask(pwm_code_reg)) == 6'h00; // R1 R2 R3
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         div_cnt_reg <= 6'h00;
         PWM_CLK_EN_O <= 1'b0;
      end else begin
         div_cnt_reg <= div_cnt_next;
         PWM_CLK_EN_O <= pwm_en_next;
      end
   end

   // ----------------------------------------------------------------------
   // PLL verification timer
   // ----------------------------------------------------------------------
   logic mon_s1_reg, mon_s2_reg, mon_s3_reg;
   logic mon_edge;
   ppc_vf_state_t vf_state_reg, vf_state_next;
   logic [15:0] vcnt_reg, vcnt_next;
   logic fail_next;

   // Monitor pin is asynchronous; edges are taken from the second and third stages only
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         mon_s1_reg <= 1'b0;
         mon_s2_reg <= 1'b0;
         mon_s3_reg <= 1'b0;
      end else begin
         mon_s1_reg <= PLL_MON_I;
         mon_s2_reg <= mon_s1_reg;
         mon_s3_reg <= mon_s2_reg;
      end
   end

   assign mon_edge = mon_s2_reg ^ mon_s3_reg;

   // Any monitor toggle restarts the watch; silence for the full
   // window flags the PLL as lost once, until it toggles again
   always_comb begin
      vf_state_next = vf_state_reg;
      vcnt_next = vcnt_reg;
      fail_next = 1'b0;
      lost_set = 1'b0;
      case (vf_state_reg)
         VF_OFF: begin
            vcnt_next = 16'h0000;
            if (verify_reg) begin
               vf_state_next = VF_WATCH; // R10
            end
         end
         VF_WATCH: begin
            if (!verify_reg) begin
               vf_state_next = VF_OFF; // R10
            end else if (mon_edge) begin
               vcnt_next = 16'h0000;
            end else if (vcnt_reg == VF_LAST) begin
               fail_next = 1'b1; // R10
               lost_set = 1'b1;
               vf_state_next = VF_LOST;
            end else begin
               vcnt_next = vcnt_reg + 16'h0001;
            end
         end
         VF_LOST: begin
            vcnt_next = 16'h0000;
            if (!verify_reg) begin
               vf_state_next = VF_OFF;
            end else if (mon_edge) begin
               vf_state_next = VF_WATCH;
            end
         end
         default: begin
            vf_state_next = VF_OFF;
         end
      endcase
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         vf_state_reg <= VF_OFF;
         vcnt_reg <= 16'h0000;
         PLL_FAIL_O <= 1'b0;
      end else begin
         vf_state_reg <= vf_state_next;
         vcnt_reg <= vcnt_next;
         PLL_FAIL_O <= fail_next;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   logic [6:0] gap_reg;

   // Cycles since the last PWM enable, for the period check
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         gap_reg <= 7'h00;
      end else if (PWM_CLK_EN_O || !pwm_sel_reg) begin
         gap_reg <= 7'h00;
      end else begin
         gap_reg <= gap_reg + 7'h01;
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   apb_ready_a: assert property (
      PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
      else $error("apb answer not one cycle");
   pwm_full_a: assert property ( // R12
      !pwm_sel_reg |=> PWM_CLK_EN_O)
      else $error("undivided pwm enable missing");
   pwm_half_a: assert property ( // R2
      (pwm_sel_reg && pwm_code_reg == 3'h0)[*3] |->
      PWM_CLK_EN_O != $past(PWM_CLK_EN_O))
      else $error("pwm divide by two wrong");
   pwm_align_a: assert property ( // R3
      PWM_CLK_EN_O && $past(pwm_sel_reg) |->
      (div_cnt_reg & pwm_mask($past(pwm_code_reg))) == 6'h00)
      else $error("pwm enable off alignment");
   pwm_slow_a: assert property ( // R1
      pwm_sel_reg |-> gap_reg < 7'h40)
      else $error("pwm enable gap above 64");
   pll_pd_a: assert property ( // R4
      wr_ctrl |=> PLL_POWER_DOWN_O == $past(PWDATA_I[`PPC_PWR_DOWN_BIT]))
      else $error("power down not following write");
   pll_outen_a: assert property ( // R5
      wr_ctrl |=> PLL_OUTPUT_ENABLE_N_O == $past(PWDATA_I[`PPC_OUT_EN_N_BIT]))
      else $error("output enable not following write");
   bypass_sel_a: assert property ( // R7
      wr_ctrl ##1 !wr_ctrl[*2] |->
      PLL_BYPASS_O == $past(PWDATA_I[`PPC_BYPASS_BIT], 2))
      else $error("bypass select lost");
   verify_off_a: assert property ( // R10
      !verify_reg |=> !PLL_FAIL_O)
      else $error("fail without verification");
   verify_fail_a: assert property ( // R10
      PLL_FAIL_O |-> $past(vcnt_reg) == VF_LAST && lost_reg)
      else $error("fail before timeout");
   rsvd_read_a: assert property ( // R11
      PRDATA_O[21] == 1'b0 && PRDATA_O[16:14] == 3'h0)
      else $error("reserved bits not zero");

   pwm_div64_c: cover property (
      pwm_sel_reg && pwm_code_reg == 3'h7 && PWM_CLK_EN_O);
   pll_fail_c: cover property (PLL_FAIL_O);
   pll_run_c: cover property (!pwr_down_reg && !out_en_n_reg && !bypass_reg);
   apb_err_c: cover property (PSLVERR_O && PREADY_O);
endmodule // ppc_clock_select

// ==== verification/ppc_clock_select_tb_top.sv ====
// Self-checking testbench of the PLL and PWM clock select block
`timescale 1ns/1ns
`include "ppc_params.svh"
module ppc_clock_select_tb_top;
   import ppc_pkg::*;
   localparam int VCYC = 8;
   logic clk_i, resetn_i, psel, penable, pwrite, pll_mon, mon_run, err;
   logic [11:0] paddr;
   ppc_word_t pwdata, prdata, rdata;
   logic pready, pslverr, pwr_dn, out_en_n, bypass, pwm_en, pll_fail;
   int mismatches = 0;
   int num_checks = 0;

   ppc_clock_select #(.VERIFY_CYCLES(VCYC)) u_dut (
      .CLK_I(clk_i), .RESETN_I(resetn_i), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .PLL_MON_I(pll_mon),
      .PLL_POWER_DOWN_O(pwr_dn), .PLL_OUTPUT_ENABLE_N_O(out_en_n),
      .PLL_BYPASS_O(bypass), .PWM_CLK_EN_O(pwm_en), .PLL_FAIL_O(pll_fail)
   );

   // ------------------------------------------------------------------
   // Clock and PLL activity monitor
   // ------------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Toggling monitor stands for a live PLL; stopping it kills the PLL
   always @(posedge clk_i) begin
      if (mon_run) pll_mon <= ~pll_mon;
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; waits up to 16 edges for the slave, then fails the run
   task automatic apb(input logic wr, input logic [11:0] a,
                      input ppc_word_t d);
      int i;
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk_i);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         mismatches++;
         report_and_stop;
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Counts edges until a sampled pulse; bounded so a dead pulse ends run
   task automatic wait_hi(input logic sel_fail, output int n);
      for (n = 1; n <= 200; n++) begin
         @(posedge clk_i);
         if ((sel_fail ? pll_fail : pwm_en) === 1'b1) break;
      end
      if (n > 200) begin
         mismatches++;
         report_and_stop;
      end
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   // Reset values at the pins and in the register
   task automatic t_reset;
      @(posedge clk_i);
      check({29'h0, pwr_dn, out_en_n, bypass}, 32'h7);
      apb(1'b0, `PPC_CTRL_OFFSET, 32'h0);
      check(rdata, 32'h000E_3800);
      check(32'(err), 32'h0);
   endtask

   // Reserved bits, pin mapping, unmapped addresses
   task automatic t_regs;
      apb(1'b1, `PPC_CTRL_OFFSET, 32'hFFFF_FFFF);
      apb(1'b0, `PPC_CTRL_OFFSET, 32'h0);
      check(rdata, 32'h001E_3C00);
      check({29'h0, pwr_dn, out_en_n, bypass}, 32'h7);
      // Pins change at the access edge, so look one edge later
      apb(1'b1, `PPC_CTRL_OFFSET, 32'h0000_2000);
      @(posedge clk_i);
      check({29'h0, pwr_dn, out_en_n, bypass}, 32'h4);
      apb(1'b1, `PPC_CTRL_OFFSET, 32'h0000_1000);
      @(posedge clk_i);
      check({29'h0, pwr_dn, out_en_n, bypass}, 32'h2);
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      check(32'(err), 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rdata, 32'h0);
      apb(1'b0, `PPC_CTRL_OFFSET, 32'h0);
      check(rdata, 32'h0000_1000);
   endtask

   // Undivided enable, then every divider code measured end to end
   task automatic t_pwm;
      int n, c;
      apb(1'b1, `PPC_CTRL_OFFSET, 32'h000E_0000);
      for (c = 0; c < 8; c++) begin
         @(posedge clk_i);
         check(32'(pwm_en), 32'h1);
      end
      for (c = 0; c < 8; c++) begin
         apb(1'b1, `PPC_CTRL_OFFSET, 32'h0010_0000 | (c << 17));
         // Two syncs flush any pulse left from the previous code
         wait_hi(1'b0, n);
         wait_hi(1'b0, n);
         wait_hi(1'b0, n);
         check(n, (c < 5) ? (2 << c) : 64);
      end
   endtask

   // Verification timer: quiet while alive, fires once when PLL dies
   task automatic t_verify;
      int n, f;
      apb(1'b1, `PPC_CTRL_OFFSET, 32'h0000_0400);
      f = 0;
      repeat (40) begin
         @(posedge clk_i);
         if (pll_fail !== 1'b0) f++;
      end
      check(f, 0);
      mon_run <= 1'b0;
      wait_hi(1'b1, n);
      check(32'(n >= VCYC && n <= VCYC + 6), 32'h1);
      @(posedge clk_i);
      check(32'(pll_fail), 32'h0);
      apb(1'b0, `PPC_STAT_OFFSET, 32'h0);
      check(rdata, 32'h1);
      apb(1'b1, `PPC_STAT_OFFSET, 32'h1);
      apb(1'b1, `PPC_CTRL_OFFSET, 32'h0);
      // Both PLL controls cleared and PLL selected before the converter
      @(posedge clk_i);
      check({29'h0, pwr_dn, out_en_n, bypass}, 32'h0);
      f = 0;
      repeat (40) begin
         @(posedge clk_i);
         if (pll_fail !== 1'b0) f++;
      end
      check(f, 0);
      apb(1'b0, `PPC_STAT_OFFSET, 32'h0);
      check(rdata, 32'h0);
      mon_run <= 1'b1;
   endtask

   // ------------------------------------------------------------------
   // Main sequence, with a second reset in mid-run
   // ------------------------------------------------------------------
   initial begin
      resetn_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pll_mon = 1'b0;
      mon_run = 1'b1;
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_reset;
      t_regs;
      t_pwm;
      t_verify;
      apb(1'b1, `PPC_CTRL_OFFSET, 32'h0010_0000);
      resetn_i <= 1'b0;
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_reset;
      report_and_stop;
   end
endmodule // ppc_clock_select_tb_top
